// [verilog/sec_cmd_pkg.sv]
// Package: offsets, field positions and reset values of the secondary command block
package sec_cmd_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFF_CMD      = 8'h44;   // Command (low half) and status (high half)
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h48;   // Sticky event status
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h4c;   // Event mask
    localparam logic [7:0]  OFF_MODE     = 8'h50;   // Bridge mode and live state
    // Command bit positions
    localparam int B_IO      = 0;
    localparam int B_MEM     = 1;
    localparam int B_MASTER  = 2;
    localparam int B_PERR    = 6;
    localparam int B_SERR    = 8;
    localparam int B_INTDIS  = 10;
    // Fixed read-only zero bits of the command half
    localparam int B_SPECIAL = 3;
    localparam int B_MWI     = 4;
    localparam int B_PALETTE = 5;
    localparam int B_WAIT    = 7;
    localparam int B_FB2B    = 9;
    // Status half: master data parity error flag
    localparam int B_MDPE    = 24;
    // Writable mask of the command half; all other bits fixed zero
    localparam logic [15:0] CMD_WMASK    = 16'h0547;
    localparam logic [15:0] CMD_RESET    = 16'h0000;
    // Event bits in the interrupt status register
    localparam int E_PERR    = 0;
    localparam int E_SERR    = 1;
    localparam int E_INTX    = 2;
    localparam int N_EV      = 3;
    localparam logic [N_EV-1:0] EV_ZERO  = 3'h0;
    // Mode register bits
    localparam int M_REVERSE = 0;
    localparam int M_PCIX    = 1;
endpackage

// [verilog/sec_cmd_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sec_cmd_sync
    import sec_cmd_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;   // First stage, read only by the second
        logic [W-1:0] s2;   // Second stage, safe to use
    } sync_s;
    sync_s st;
    sync_s next_st;

    // Shift chain
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // Register the chain; reset to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// [verilog/sec_cmd_events.sv]
// Sticky event status with write-one-to-clear and mask-gated interrupt
`timescale 1ns/1ps
module sec_cmd_events
    import sec_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Event pulses and clear strobe
    input  wire logic [N_EV-1:0] ev,
    input  wire logic [N_EV-1:0] clr,
    input  wire logic [N_EV-1:0] mask,
    // State out
    output logic      [N_EV-1:0] stat,
    output logic                 irq
);
    typedef struct packed {
        logic [N_EV-1:0] stat;  // Sticky bits
    } ev_s;
    ev_s st;
    ev_s next_st;

    // Set wins over clear so a coincident event is never lost
    always_comb begin
        next_st.stat = (st.stat & ~clr) | ev;
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            st.stat <= EV_ZERO;
        end else begin
            st <= next_st;
        end
    end

    assign stat = st.stat;
    // Level interrupt while any unmasked bit is set
    assign irq  = |(st.stat & mask);
endmodule

// [verilog/sec_cmd_regs.sv]
// Secondary command register bank with APB slave and bridge gating outputs
`timescale 1ns/1ps
//
// Overview of operation
// RL1: I/O enable clear ignores secondary I/O
// RL2: Memory enable clear ignores secondary memory reads
// RL3: Master enable clear blocks initiate and respond
// RL4: Reverse PCI-X split completions ignore master enable
// RL5: Special cycle bit reads zero, never responds
// RL6: Invalidate enable reads zero, forwarding only
// RL7: Palette snoop bit zero, snoops ignored
// RL8: Parity response enables parity error flag
// RL9: Wait cycle control is read-only
// RL10: Forward mode error enable gates messages
// RL11: Reverse mode error enable gates SERR
// RL12: Fast back-to-back enable reads zero
// RL13: Interrupt disable blocks INTx messages
// RL14: Interrupt disable releases asserted INTx
// RL15: Parity flag set only when enabled
// RL16: Reserved bits read zero, writes ignored
// RL17: Writes to read-only bits ignored
module sec_cmd_regs
    import sec_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Bridge mode straps (pins)
    input  wire logic        reverse_mode_pin,
    input  wire logic        pcix_mode_pin,
    // Error and interrupt requests from the bridge core (same clock)
    input  wire logic        parity_event,
    input  wire logic        sys_error_event,
    input  wire logic        intx_request,
    // Secondary interface gating
    output logic             io_respond_en,
    output logic             mem_read_en,
    output logic             master_en,
    output logic             split_compl_en,
    output logic             special_cycle_respond,
    output logic             mwi_originate_en,
    output logic             palette_snoop_en,
    output logic             err_msg_en,
    output logic             serr_assert,
    output logic             intx_assert,
    // Interrupt
    output logic             irq
);
    // Synchronised mode straps
    logic [1:0]      mode_sync;
    logic            rev;
    logic            pcix;
    logic [N_EV-1:0] ev_stat;
    logic [N_EV-1:0] ev_clr;

    // Whole module state
    typedef struct packed {
        logic [15:0]     cmd;      // Command half
        logic            mdpe;     // Master data parity error flag
        logic [N_EV-1:0] mask;     // Interrupt mask
        logic            serr;     // Registered SERR drive
        logic            intx;     // Registered INTx drive
        logic [31:0]     rdata;    // Read data hold
        logic            ready;    // Access phase answer
    } regs_s;
    regs_s st;
    regs_s next_st;

    // Bus decode helper, used by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Mode straps come from pins: two flops before use
    sec_cmd_sync #(.W(2)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({pcix_mode_pin, reverse_mode_pin}),
        .q   (mode_sync)
    );
    assign rev  = mode_sync[M_REVERSE];
    assign pcix = mode_sync[M_PCIX];

    // Sticky event bank
    sec_cmd_events u_events (
        .clk  (clk),
        .rst  (rst),
        .ev   ({intx_request, sys_error_event, parity_event}),
        .clr  (ev_clr),
        .mask (st.mask),
        .stat (ev_stat),
        .irq  (irq)
    );

    logic acc;
    logic wr;
    assign acc = psel & penable & st.ready;
    assign wr  = acc & pwrite;
    // Write-one-to-clear of event status
    assign ev_clr = (wr && hit(paddr, OFF_IRQ_STAT)) ? pwdata[N_EV-1:0] : EV_ZERO;

    // Next-state logic: register writes, flag updates, read mux
    always_comb begin
        next_st = st;
        // One wait state: ready rises in the access phase, falls after
        next_st.ready = psel & penable & ~st.ready;
        if (wr && hit(paddr, OFF_CMD)) begin
            // Only writable bits take data; fixed and reserved stay zero
            next_st.cmd = pwdata[15:0] & CMD_WMASK;           // [RL16] [RL17] [RL9] [RL12]
            // Status half: write one clears master parity flag
            if (pwdata[B_MDPE]) begin
                next_st.mdpe = 1'b0;
            end
        end
        if (wr && hit(paddr, OFF_IRQ_MASK)) begin
            next_st.mask = pwdata[N_EV-1:0];
        end
        // Parity flag gated by response enable; set wins over clear
        if (parity_event && st.cmd[B_PERR]) begin
            next_st.mdpe = 1'b1;                              // [RL8] [RL15]
        end
        // SERR driven only in reverse mode with enable
        next_st.serr = rev & st.cmd[B_SERR] & sys_error_event;     // [RL11]
        // Disable releases any held INTx at once
        next_st.intx = intx_request & ~next_st.cmd[B_INTDIS];     // [RL13] [RL14]
        // Read mux; unmapped reads return zero with error
        next_st.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, OFF_CMD)) begin
                next_st.rdata = {7'h00, st.mdpe, 8'h00, st.cmd};
            end else if (hit(paddr, OFF_IRQ_STAT)) begin
                next_st.rdata = {29'h0, ev_stat};
            end else if (hit(paddr, OFF_IRQ_MASK)) begin
                next_st.rdata = {29'h0, st.mask};
            end else if (hit(paddr, OFF_MODE)) begin
                next_st.rdata = {25'h0, st.intx, st.serr, 3'h0, pcix, rev};
            end
        end else if (psel && penable) begin
            next_st.rdata = st.rdata;
        end
    end

    // Single state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // APB answers
    assign pready  = st.ready;
    assign prdata  = st.rdata;
    assign pslverr = st.ready & ~(hit(paddr, OFF_CMD) | hit(paddr, OFF_IRQ_STAT)
                                  | hit(paddr, OFF_IRQ_MASK) | hit(paddr, OFF_MODE));

    // Gating outputs
    assign io_respond_en  = st.cmd[B_IO] & st.cmd[B_MASTER];            // [RL1] [RL3]
    assign mem_read_en    = st.cmd[B_MEM] & st.cmd[B_MASTER];           // [RL2] [RL3]
    assign master_en      = st.cmd[B_MASTER];                           // [RL3]
    assign split_compl_en = st.cmd[B_MASTER] | (rev & pcix);            // [RL4]
    assign special_cycle_respond = 1'b0;                                // [RL5]
    // Originated invalidates never; forwarding path is outside this bank
    assign mwi_originate_en = 1'b0;                                     // [RL6]
    assign palette_snoop_en = 1'b0;                                     // [RL7]
    assign err_msg_en     = ~rev & st.cmd[B_SERR];                      // [RL10]
    assign serr_assert    = st.serr;
    assign intx_assert    = st.intx;

    // Low half of write data as a plain signal, so the checks can look back at it
    logic [15:0] wr_low;
    assign wr_low = pwdata[15:0];

    // Assertions
    property p_rsvd_zero;
        @(posedge clk) disable iff (rst) (st.cmd & ~CMD_WMASK) == 16'h0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("fixed bits not zero"); // [RL16]

    property p_ro_write;
        @(posedge clk) disable iff (rst)
            (wr && hit(paddr, OFF_CMD)) |=> (st.cmd == ($past(wr_low) & CMD_WMASK));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only bit took data"); // [RL17]

    property p_io_gate;
        @(posedge clk) disable iff (rst) !st.cmd[B_IO] |-> !io_respond_en;
    endproperty
    a_io_gate: assert property (p_io_gate) else $error("io response while off"); // [RL1]

    property p_mem_gate;
        @(posedge clk) disable iff (rst) !st.cmd[B_MEM] |-> !mem_read_en;
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("mem read while off"); // [RL2]

    property p_split;
        @(posedge clk) disable iff (rst) (rev && pcix) |-> split_compl_en;
    endproperty
    a_split: assert property (p_split) else $error("split completion blocked"); // [RL4]

    property p_mdpe_set;
        @(posedge clk) disable iff (rst)
            $rose(st.mdpe) |-> $past(parity_event) && $past(st.cmd[B_PERR]);
    endproperty
    a_mdpe_set: assert property (p_mdpe_set) else $error("parity flag set wrongly"); // [RL15]

    property p_mdpe_cause;
        @(posedge clk) disable iff (rst) (parity_event && st.cmd[B_PERR]) |=> st.mdpe;
    endproperty
    a_mdpe_cause: assert property (p_mdpe_cause) else $error("parity flag missed"); // [RL8]

    property p_intx_release;
        @(posedge clk) disable iff (rst) st.cmd[B_INTDIS] |-> !intx_assert;
    endproperty
    a_intx_release: assert property (p_intx_release) else $error("intx while disabled"); // [RL14]

    property p_serr_mode;
        @(posedge clk) disable iff (rst) serr_assert |-> $past(rev) && $past(st.cmd[B_SERR]);
    endproperty
    a_serr_mode: assert property (p_serr_mode) else $error("serr without enable"); // [RL11]

    property p_errmsg;
        @(posedge clk) disable iff (rst) err_msg_en |-> (!rev && st.cmd[B_SERR]);
    endproperty
    a_errmsg: assert property (p_errmsg) else $error("error message gate wrong"); // [RL10]

    // Forward mode with the enable set must open the message path
    property p_errmsg_on;
        @(posedge clk) disable iff (rst) (!rev && st.cmd[B_SERR]) |-> err_msg_en;
    endproperty
    a_errmsg_on: assert property (p_errmsg_on) else $error("errmsg gate off"); // [RL10]

    // Master bit low closes the master, I/O response and memory read gates
    property p_master_gate;
        @(posedge clk) disable iff (rst)
            !st.cmd[B_MASTER] |-> (!master_en && !io_respond_en && !mem_read_en);
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("master gate open"); // [RL3]

    // Outside reverse PCI-X the split path follows the master bit only
    property p_split_master;
        @(posedge clk) disable iff (rst)
            !(rev && pcix) |-> (split_compl_en == st.cmd[B_MASTER]);
    endproperty
    a_split_master: assert property (p_split_master) else $error("split gate wrong"); // [RL4]

    // Fixed-zero capability bits and their gates never come alive
    property p_special;
        @(posedge clk) disable iff (rst) !special_cycle_respond && !st.cmd[B_SPECIAL];
    endproperty
    a_special: assert property (p_special) else $error("special cycle enabled"); // [RL5]

    property p_mwi;
        @(posedge clk) disable iff (rst) !mwi_originate_en && !st.cmd[B_MWI];
    endproperty
    a_mwi: assert property (p_mwi) else $error("invalidate enabled"); // [RL6]

    property p_palette;
        @(posedge clk) disable iff (rst) !palette_snoop_en && !st.cmd[B_PALETTE];
    endproperty
    a_palette: assert property (p_palette) else $error("palette snoop enabled"); // [RL7]

    property p_wait_ro;
        @(posedge clk) disable iff (rst)
            (wr && hit(paddr, OFF_CMD)) |=> !st.cmd[B_WAIT];
    endproperty
    a_wait_ro: assert property (p_wait_ro) else $error("wait cycle bit took data"); // [RL9]

    property p_fb2b_ro;
        @(posedge clk) disable iff (rst) !st.cmd[B_FB2B];
    endproperty
    a_fb2b_ro: assert property (p_fb2b_ro) else $error("fast b2b bit set"); // [RL12]

    // Parity flag cannot appear while response is off, and stays until cleared
    property p_mdpe_off;
        @(posedge clk) disable iff (rst)
            (!st.cmd[B_PERR] && !st.mdpe) |=> !st.mdpe;
    endproperty
    a_mdpe_off: assert property (p_mdpe_off) else $error("parity flag set while off"); // [RL15]

    property p_mdpe_hold;
        @(posedge clk) disable iff (rst)
            (st.mdpe && !(wr && hit(paddr, OFF_CMD) && pwdata[B_MDPE])) |=> st.mdpe;
    endproperty
    a_mdpe_hold: assert property (p_mdpe_hold) else $error("parity flag lost"); // [RL8]

    // INTx drive needs a request, and follows one while not disabled
    property p_intx_gate;
        @(posedge clk) disable iff (rst) intx_assert |-> $past(intx_request);
    endproperty
    a_intx_gate: assert property (p_intx_gate) else $error("intx without request"); // [RL13]

    property p_intx_follow;
        @(posedge clk) disable iff (rst)
            (intx_request && !st.cmd[B_INTDIS] && !(wr && hit(paddr, OFF_CMD))) |=> intx_assert;
    endproperty
    a_intx_follow: assert property (p_intx_follow) else $error("intx request dropped"); // [RL13]

    // Reverse mode SERR follows an enabled error one cycle later
    property p_serr_cause;
        @(posedge clk) disable iff (rst)
            (rev && st.cmd[B_SERR] && sys_error_event) |=> serr_assert;
    endproperty
    a_serr_cause: assert property (p_serr_cause) else $error("serr missed"); // [RL11]
endmodule

// [tb/sec_core_model.sv]
// Behavioural bridge core that raises parity, system error and INTx requests
`timescale 1ns/1ps
module sec_core_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Controls from the bench
    input  wire logic par_go,
    input  wire logic serr_go,
    input  wire logic intx_go,
    // Requests toward the register bank
    output logic      parity_event,
    output logic      sys_error_event,
    output logic      intx_request
);
    // Registered so requests change just after an edge, like real core logic
    always_ff @(posedge clk) begin
        if (rst) begin
            parity_event    <= 1'b0;
            sys_error_event <= 1'b0;
            intx_request    <= 1'b0;
        end else begin
            parity_event    <= par_go;   // One cycle while the bench pulses it
            sys_error_event <= serr_go;  // Level, held by the bench
            intx_request    <= intx_go;  // Level, held by the bench
        end
    end
endmodule

// [tb/secondary_command_register_bench.sv]
// Self-checking bench for the secondary command register bank
`timescale 1ns/1ps
module secondary_command_register_bench;
    import sec_cmd_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, rev = 0, pcix = 0;
    logic        par_go = 0, serr_go = 0, intx_go = 0, par_ev, serr_ev, intx_rq;
    logic        io_en, mem_en, mst_en, split_en, spc, mwi, pal, errm, serr_o, intx_o, irq;
    int          miscompares = 0, checks = 0;
    // Table rows: command written, word read back, gating outputs expected
    typedef struct packed {logic [31:0] w; logic [31:0] r; logic [7:0] g;} row_s;
    row_s rows [4] = '{'{32'h0000ffff, 32'h00000547, 8'hf1}, '{32'h00000003, 32'h3, 8'h00},
                       '{32'h00000005, 32'h5, 8'hb0}, '{32'h00000100, 32'h100, 8'h01}};

    always #10 clk = ~clk;

    sec_core_model core (.clk(clk), .rst(rst), .par_go(par_go), .serr_go(serr_go),
        .intx_go(intx_go), .parity_event(par_ev), .sys_error_event(serr_ev),
        .intx_request(intx_rq));

    sec_cmd_regs dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .reverse_mode_pin(rev), .pcix_mode_pin(pcix), .parity_event(par_ev),
        .sys_error_event(serr_ev), .intx_request(intx_rq), .io_respond_en(io_en),
        .mem_read_en(mem_en), .master_en(mst_en), .split_compl_en(split_en),
        .special_cycle_respond(spc), .mwi_originate_en(mwi), .palette_snoop_en(pal),
        .err_msg_en(errm), .serr_assert(serr_o), .intx_assert(intx_o), .irq(irq));

    // One comparison; a mismatch is reported at once
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Closing report, the only place the run ends
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;  // Slave never answered
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask

    // Read and compare in one step
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // Wait a few edges so registered outputs and the strap synchroniser settle
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // Single parity pulse from the core
    task automatic par_pulse();
        @(posedge clk) par_go <= 1;
        @(posedge clk) par_go <= 0;
        settle();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        rchk("cmd reset", OFF_CMD, 32'h0);
        rchk("mode reset", OFF_MODE, 32'h0);
        // Table: written value, read-back and gating outputs, forward mode
        foreach (rows[i]) begin
            apb(1, OFF_CMD, rows[i].w);
            rchk("cmd read", OFF_CMD, rows[i].r);
            chk("gating", {24'h0, io_en, mem_en, mst_en, split_en, spc, mwi, pal, errm},
                {24'h0, rows[i].g});
        end
        // Parity flag gated by the response enable; event bit is not
        apb(1, OFF_CMD, 32'h0);
        par_pulse();
        rchk("mdpe off", OFF_CMD, 32'h0);
        rchk("ev stat", OFF_IRQ_STAT, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1, OFF_IRQ_MASK, 32'h1);
        settle();
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1, OFF_IRQ_STAT, 32'h7);
        settle();
        chk("irq clr", {31'h0, irq}, 32'h0);
        apb(1, OFF_CMD, 32'h40);
        par_pulse();
        rchk("mdpe on", OFF_CMD, 32'h01000040);
        apb(1, OFF_CMD, 32'h01000040);
        rchk("mdpe w1c", OFF_CMD, 32'h40);
        // INTx raised, then released by the interrupt disable bit
        intx_go <= 1;
        settle();
        chk("intx on", {31'h0, intx_o}, 32'h1);
        rchk("mode intx", OFF_MODE, 32'h40);
        apb(1, OFF_CMD, 32'h400);
        settle();
        chk("intx off", {31'h0, intx_o}, 32'h0);
        intx_go <= 0;
        // Reverse PCI-X mode: split completions and SERR path
        rev <= 1; pcix <= 1; serr_go <= 1;
        apb(1, OFF_CMD, 32'h100);
        settle();
        chk("split", {31'h0, split_en}, 32'h1);
        chk("err msg", {31'h0, errm}, 32'h0);
        chk("serr on", {31'h0, serr_o}, 32'h1);
        rchk("mode rev", OFF_MODE, 32'h23);
        apb(1, OFF_CMD, 32'h0);
        settle();
        chk("serr off", {31'h0, serr_o}, 32'h0);
        chk("split nm", {31'h0, split_en}, 32'h1);
        serr_go <= 0;
        // Reverse bridge on a plain PCI secondary: split path needs the master bit
        pcix <= 0;
        settle();
        chk("split pci", {31'h0, split_en}, 32'h0);
        // Unmapped address is refused
        rchk("unmapped", 8'h60, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        // Second reset in mid-run clears a programmed command word
        apb(1, OFF_CMD, 32'h547);
        rst <= 1;
        repeat (3) @(posedge clk);
        rst <= 0;
        chk("rst gating", {24'h0, io_en, mem_en, mst_en, split_en, spc, mwi, pal, errm},
            32'h0);
        chk("rst irq", {31'h0, irq}, 32'h0);
        rchk("cmd rst2", OFF_CMD, 32'h0);
        results();
    end
endmodule
